// file: logic/cpu_program_sequencer.sv
// Purpose: Program counter, return stack, context shadows and pointers.
// Assumes: The core pulses step once per completed instruction.
// Notes: Registers sit behind an Avalon-MM slave with waitrequest.
// Operation
// [RULE_01] The return stack holds sixteen 15-bit program counter values.
// [RULE_02] Pushing a full stack or popping an empty one sets a status flag.
// [RULE_03] With the stack reset option on, a stack error resets the core.
// [RULE_04] Interrupt entry saves core registers; interrupt return restores.
// [RULE_05] Two 16-bit pointers reach all file registers and program memory.
// [RULE_06] A pointer access to program memory takes one extra cycle; here only reads do, discarded writes end in one cycle.
// [RULE_07] Pointers see general purpose RAM as one linear space.
// [RULE_08] The program counter is 15 bits, spanning 32K words of 14 bits.
// [RULE_09] Addresses past the implemented memory wrap inside it.
// [RULE_10] Any reset loads the program counter with address zero.
// [RULE_11] Interrupt entry pushes the return address and jumps to four.
// [RULE_12] The instruction set has exactly forty-nine instructions.
// [RULE_13] A pointer with bit 15 set addresses program memory.
// [RULE_14] A program memory read returns only the low eight bits.
// [RULE_15] Pointer writes to program memory are discarded.
// [RULE_16] Calls and interrupts push the return address; returns pop it.
// [RULE_17] The stack reset option is a strap caught during reset.
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module cpu_program_sequencer #(
   parameter int PM_WORDS = seq_pkg::PM_WORDS_DEFAULT
)(
   input wire logic clk,
   input wire logic rst,
   input wire logic stack_reset_strap,
   input wire logic [2:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   input wire logic step,
   input wire logic call,
   input wire logic ret,
   input wire logic retfie,
   input wire logic irq_take,
   input wire logic jump,
   input wire logic [14:0] target,
   input wire logic [31:0] ctx_in,
   output logic [31:0] ctx_out,
   output logic ctx_restore,
   output logic soft_reset,
   output logic [14:0] pc,
   output logic [14:0] pm_addr,
   input wire logic [13:0] pm_rdata,
   input wire logic ptr_wr,
   input wire logic ptr_sel,
   input wire logic [15:0] ptr_wdata,
   input wire logic ind_req,
   input wire logic ind_write,
   input wire logic ind_sel,
   input wire logic [7:0] ind_wdata,
   output logic [7:0] ind_rdata,
   output logic ind_done,
   output logic ind_busy,
   output logic [11:0] dm_addr,
   output logic dm_rd,
   output logic dm_wr,
   output logic [7:0] dm_wdata,
   input wire logic [7:0] dm_rdata
);
   typedef struct packed
   {
      seq_pkg::access_state_type st;
      logic [14:0] pc;
      logic [4:0] depth;
      logic ovf;
      logic unf;
      logic [1:0] mask;
      logic irq;
      logic waitreq;
      logic [31:0] rdata;
      logic [14:0] pm_addr;
      logic [11:0] dm_addr;
      logic dm_rd;
      logic dm_wr;
      logic [7:0] dm_wdata;
      logic [7:0] ind_rdata;
      logic ind_done;
      logic ind_pm;
      logic busy;
      logic soft_reset;
      logic [31:0] shadow;
      logic [31:0] ctx_out;
      logic ctx_restore;
      logic stk_rst_en;
   } seq_state_type;

   localparam logic [14:0] PM_MASK = 15'(PM_WORDS - 1);

   seq_state_type r;
   seq_state_type next_r;
   logic [14:0] top;
   logic [3:0] rd_addr;
   logic push;
   logic pop;
   logic ovf_evt;
   logic unf_evt;
   logic stk_err;
   logic push_wr;
   logic [14:0] ret_addr;
   logic wr_go;
   logic [4:0] wr_off;
   logic [4:0] rd_off;
   logic bus_ptr_wr;
   logic ptr_save;
   logic ptr_restore;
   logic [15:0] ptr0;
   logic [15:0] ptr1;
   logic acc_pm;
   logic [14:0] acc_pm_addr;
   logic [11:0] acc_dm_addr;
   logic acc_go;
   logic [31:0] reg_rd;

   // Stack pushes and pops on each completed instruction.
   always_comb
   begin
      push = step && (irq_take || (call && !ret && !retfie)); // RULE_16
      pop = step && !irq_take && (ret || retfie); // RULE_16
      ovf_evt = push && r.depth == seq_pkg::DEPTH_FULL; // RULE_02
      unf_evt = pop && r.depth == seq_pkg::DEPTH_EMPTY; // RULE_02
      stk_err = ovf_evt || unf_evt;
      push_wr = push && !ovf_evt;
      ret_addr = r.pc + 15'h0001;
      ptr_save = step && irq_take; // RULE_04
      ptr_restore = pop && retfie && !stk_err; // RULE_04
   end

   // Bus decode; a write takes effect where waitrequest is seen low.
   always_comb
   begin
      wr_go = avs_write && !r.waitreq;
      wr_off = {avs_address, 2'b00};
      rd_off = {avs_address, 2'b00};
      bus_ptr_wr = wr_go && (wr_off == seq_pkg::OFF_PTR0
         || wr_off == seq_pkg::OFF_PTR1);
      acc_go = ind_req && r.st == seq_pkg::ACC_IDLE;
   end

   // Register read multiplexer; unmapped offsets read zero.
   always_comb
   begin
      reg_rd = 32'h00000000;
      case (rd_off)
         seq_pkg::OFF_POWER_CONTROL_STATUS:
         begin
            reg_rd[seq_pkg::POWER_CONTROL_STATUS_OVF_BIT] = r.ovf;
            reg_rd[seq_pkg::POWER_CONTROL_STATUS_UNF_BIT] = r.unf;
         end
         seq_pkg::OFF_MASK: reg_rd[1:0] = r.mask;
         seq_pkg::OFF_PC: reg_rd[14:0] = r.pc; // RULE_08
         seq_pkg::OFF_DEPTH: reg_rd[4:0] = r.depth;
         seq_pkg::OFF_PTR0: reg_rd[15:0] = ptr0;
         seq_pkg::OFF_PTR1: reg_rd[15:0] = ptr1;
         seq_pkg::OFF_INFO:
         begin
            reg_rd[7:0] = seq_pkg::INSTR_COUNT; // RULE_12
            reg_rd[8] = r.stk_rst_en;
         end
         default: reg_rd = 32'h00000000;
      endcase
   end

   // Next state of the whole sequencer.
   always_comb
   begin
      next_r = r;
      next_r.dm_rd = 1'b0;
      next_r.dm_wr = 1'b0;
      next_r.ind_done = 1'b0;
      next_r.soft_reset = 1'b0;
      next_r.ctx_restore = 1'b0;
      // Bus handshake: one wait cycle, then the answer.
      next_r.waitreq = 1'b1;
      if ((avs_read || avs_write) && r.waitreq)
      begin
         next_r.waitreq = 1'b0;
         next_r.rdata = avs_read ? reg_rd : 32'h00000000;
      end
      if (wr_go && wr_off == seq_pkg::OFF_MASK && avs_byteenable[0])
      begin
         next_r.mask = avs_writedata[1:0];
      end
      // Sticky flags: write one to clear, a new event wins.
      if (wr_go && wr_off == seq_pkg::OFF_POWER_CONTROL_STATUS && avs_byteenable[0])
      begin
         next_r.ovf = r.ovf && !avs_writedata[seq_pkg::POWER_CONTROL_STATUS_OVF_BIT];
         next_r.unf = r.unf && !avs_writedata[seq_pkg::POWER_CONTROL_STATUS_UNF_BIT];
      end
      next_r.ovf = next_r.ovf || ovf_evt; // RULE_02
      next_r.unf = next_r.unf || unf_evt; // RULE_02
      // Program flow, interrupt first.
      if (step)
      begin
         next_r.pc = ret_addr;
         if (irq_take)
         begin
            next_r.pc = seq_pkg::IRQ_VECTOR; // RULE_11
            next_r.shadow = ctx_in; // RULE_04
         end
         else if (ret || retfie)
         begin
            if (!unf_evt)
            begin
               next_r.pc = top; // RULE_16
            end
            if (retfie && !unf_evt)
            begin
               next_r.ctx_out = r.shadow; // RULE_04
               next_r.ctx_restore = 1'b1;
            end
         end
         else if (call || jump)
         begin
            next_r.pc = target;
         end
         if (push_wr)
         begin
            next_r.depth = r.depth + 5'h01; // RULE_01
         end
         else if (pop && !unf_evt)
         begin
            next_r.depth = r.depth - 5'h01;
         end
      end
      // Indirect access sequence.
      case (r.st)
         seq_pkg::ACC_IDLE:
         begin
            if (acc_go)
            begin
               next_r.ind_pm = acc_pm;
               if (acc_pm && ind_write)
               begin
                  next_r.ind_done = 1'b1; // RULE_15
               end
               else if (acc_pm)
               begin
                  next_r.st = seq_pkg::ACC_EXTRA; // RULE_06
               end
               else
               begin
                  next_r.st = seq_pkg::ACC_DATA;
                  next_r.dm_addr = acc_dm_addr;
                  next_r.dm_rd = !ind_write;
                  next_r.dm_wr = ind_write;
                  next_r.dm_wdata = ind_wdata;
               end
            end
         end
         seq_pkg::ACC_EXTRA: next_r.st = seq_pkg::ACC_DATA;
         seq_pkg::ACC_DATA:
         begin
            next_r.st = seq_pkg::ACC_IDLE;
            next_r.ind_done = 1'b1;
            if (r.ind_pm)
            begin
               next_r.ind_rdata = pm_rdata[7:0]; // RULE_14
            end
            else if (!r.dm_wr)
            begin
               next_r.ind_rdata = dm_rdata;
            end
         end
         default: next_r.st = seq_pkg::ACC_IDLE;
      endcase
      next_r.busy = next_r.st != seq_pkg::ACC_IDLE;
      // Program memory port: pointer read while fetching, else the pc.
      next_r.pm_addr = next_r.pc & PM_MASK; // RULE_09
      if (next_r.st == seq_pkg::ACC_EXTRA)
      begin
         next_r.pm_addr = acc_pm_addr & PM_MASK; // RULE_09
      end
      else if (r.st == seq_pkg::ACC_EXTRA)
      begin
         next_r.pm_addr = r.pm_addr;
      end
      // A stack error with the option on restarts at the reset vector.
      if (stk_err && r.stk_rst_en)
      begin
         next_r.soft_reset = 1'b1; // RULE_03
         next_r.pc = seq_pkg::RESET_VECTOR; // RULE_03
         next_r.depth = seq_pkg::DEPTH_EMPTY;
         next_r.pm_addr = seq_pkg::RESET_VECTOR;
         next_r.ctx_restore = 1'b0;
      end
      next_r.irq = |({next_r.ovf, next_r.unf} & next_r.mask);
      if (rst)
      begin
         next_r = '0;
         next_r.st = seq_pkg::ACC_IDLE;
         next_r.waitreq = 1'b1;
         next_r.pc = seq_pkg::RESET_VECTOR; // RULE_10
         next_r.pm_addr = seq_pkg::RESET_VECTOR;
         next_r.stk_rst_en = stack_reset_strap; // RULE_17
      end
   end

   // Register the whole state.
   always_ff @(posedge clk)
   begin
      r <= next_r;
   end

   // Stack read address tracks the entry on top after this cycle.
   assign rd_addr = 4'(next_r.depth - 5'h01);

   stack_mem #(
      .WIDTH(seq_pkg::PC_WIDTH),
      .DEPTH(seq_pkg::STACK_DEPTH),
      .AW(seq_pkg::STACK_AW)
   ) u_stack (
      .clk(clk),
      .wr_en(push_wr && !rst),
      .wr_addr(r.depth[3:0]),
      .wr_data(ret_addr),
      .rd_addr(rd_addr),
      .rd_data(top)
   );

   ptr_unit u_ptr (
      .clk(clk),
      .rst(rst || r.soft_reset),
      .save(ptr_save),
      .restore(ptr_restore),
      .core_wr(ptr_wr),
      .core_sel(ptr_sel),
      .core_wdata(ptr_wdata),
      .bus_wr(bus_ptr_wr),
      .bus_sel(wr_off == seq_pkg::OFF_PTR1),
      .bus_be(avs_byteenable[1:0]),
      .bus_wdata(avs_writedata[15:0]),
      .acc_sel(ind_sel),
      .ptr0(ptr0),
      .ptr1(ptr1),
      .is_pm(acc_pm),
      .pm_addr(acc_pm_addr),
      .dm_addr(acc_dm_addr)
   );

   // Outputs come straight from the state register.
   assign avs_readdata = r.rdata;
   assign avs_waitrequest = r.waitreq;
   assign irq = r.irq;
   assign ctx_out = r.ctx_out;
   assign ctx_restore = r.ctx_restore;
   assign soft_reset = r.soft_reset;
   assign pc = r.pc;
   assign pm_addr = r.pm_addr;
   assign ind_rdata = r.ind_rdata;
   assign ind_done = r.ind_done;
   assign ind_busy = r.busy;
   assign dm_addr = r.dm_addr;
   assign dm_rd = r.dm_rd;
   assign dm_wr = r.dm_wr;
   assign dm_wdata = r.dm_wdata;

   // Checks on the sequencer behaviour.
   chk_stack_bound: assert property (@(posedge clk) disable iff (rst) // RULE_01
      r.depth <= seq_pkg::DEPTH_FULL)
      else $error("stack depth above sixteen");
   chk_ovf_flag: assert property (@(posedge clk) disable iff (rst) // RULE_02
      ovf_evt |=> r.ovf && $stable(r.depth) || r.soft_reset)
      else $error("overflow not flagged");
   chk_unf_flag: assert property (@(posedge clk) disable iff (rst) // RULE_02
      unf_evt |=> r.unf)
      else $error("underflow not flagged");
   chk_err_reset: assert property (@(posedge clk) disable iff (rst) // RULE_03
      stk_err && r.stk_rst_en |=> soft_reset && pc == 15'h0000
         && r.depth == 5'h00)
      else $error("stack error did not reset");
   chk_ctx_restore: assert property (@(posedge clk) disable iff (rst) // RULE_04
      step && !irq_take && retfie && !unf_evt
         |=> ctx_restore && ctx_out == $past(r.shadow))
      else $error("context not restored");
   chk_pm_extra: assert property (@(posedge clk) disable iff (rst) // RULE_06
      acc_go && acc_pm && !ind_write |=>
         (!ind_done && ind_busy) [*2] ##1 ind_done)
      else $error("program memory read timing wrong");
   chk_data_time: assert property (@(posedge clk) disable iff (rst) // RULE_06
      acc_go && !acc_pm |-> ##2 ind_done)
      else $error("data access timing wrong");
   chk_low_byte: assert property (@(posedge clk) disable iff (rst) // RULE_14
      ind_done && r.ind_pm && !$past(acc_go)
         |-> ind_rdata == $past(pm_rdata[7:0]))
      else $error("program memory byte wrong");
   chk_pm_nowrite: assert property (@(posedge clk) disable iff (rst) // RULE_15
      acc_go && acc_pm && ind_write |=> ind_done && !dm_wr && !ind_busy)
      else $error("program memory write not discarded");
   chk_pm_wrap: assert property (@(posedge clk) disable iff (rst) // RULE_09
      (pm_addr & ~PM_MASK) == 15'h0000)
      else $error("fetch address outside memory");
   chk_reset_pc: assert property (@(posedge clk) // RULE_10
      $past(rst) |-> pc == 15'h0000 && r.depth == 5'h00)
      else $error("reset vector not loaded");
   chk_irq_vector: assert property (@(posedge clk) disable iff (rst) // RULE_11
      step && irq_take && !ovf_evt |=> pc == 15'h0004
         && r.depth == $past(r.depth) + 5'h01)
      else $error("interrupt vector not loaded");
endmodule : cpu_program_sequencer

// file: logic/ptr_unit.sv
// Purpose: Two 16-bit indirect pointers with shadows and address decode.
// Assumes: Core writes win over bus writes in the same cycle.
// Notes: Bit 15 selects program memory; 2000h to 29FFh is linear GPR space.
`timescale 1ns/1ps
module ptr_unit (
   input wire logic clk,
   input wire logic rst,
   input wire logic save,
   input wire logic restore,
   input wire logic core_wr,
   input wire logic core_sel,
   input wire logic [15:0] core_wdata,
   input wire logic bus_wr,
   input wire logic bus_sel,
   input wire logic [1:0] bus_be,
   input wire logic [15:0] bus_wdata,
   input wire logic acc_sel,
   output logic [15:0] ptr0,
   output logic [15:0] ptr1,
   output logic is_pm,
   output logic [14:0] pm_addr,
   output logic [11:0] dm_addr
);
   typedef struct packed
   {
      logic [1:0][15:0] ptr;
      logic [1:0][15:0] shadow;
   } ptr_state_type;

   ptr_state_type r;
   ptr_state_type next_r;
   logic [15:0] sel_ptr;
   logic [15:0] offset;
   logic [15:0] bank;
   logic [15:0] index;

   // Save on interrupt entry, apply writes, restore on interrupt return.
   always_comb
   begin
      next_r = r;
      if (save)
      begin
         next_r.shadow = r.ptr; // RULE_04
      end
      if (bus_wr)
      begin
         for (int b = 0; b < 2; b++)
         begin
            if (bus_be[b])
            begin
               next_r.ptr[bus_sel][b*8 +: 8] = bus_wdata[b*8 +: 8];
            end
         end
      end
      if (core_wr)
      begin
         next_r.ptr[core_sel] = core_wdata; // RULE_05
      end
      if (restore)
      begin
         next_r.ptr = r.shadow; // RULE_04
      end
      if (rst)
      begin
         next_r = '0;
      end
   end

   // Register the whole state.
   always_ff @(posedge clk)
   begin
      r <= next_r;
   end

   // Decode the selected pointer into program or data memory addresses.
   always_comb
   begin
      sel_ptr = r.ptr[acc_sel];
      offset = sel_ptr - seq_pkg::LINEAR_BASE;
      bank = offset / seq_pkg::GPR_BANK_BYTES;
      index = offset % seq_pkg::GPR_BANK_BYTES;
      is_pm = sel_ptr[seq_pkg::PTR_PM_BIT]; // RULE_13
      pm_addr = sel_ptr[14:0];
      if (sel_ptr >= seq_pkg::LINEAR_BASE && sel_ptr <= seq_pkg::LINEAR_LAST)
      begin
         dm_addr = {bank[4:0], 7'(seq_pkg::GPR_OFFSET + index[6:0])}; // RULE_07
      end
      else
      begin
         dm_addr = sel_ptr[11:0];
      end
   end

   assign ptr0 = r.ptr[0];
   assign ptr1 = r.ptr[1];
endmodule : ptr_unit

// file: logic/seq_pkg.sv
// Purpose: Shared constants and types of the program sequencer.
// Assumes: Registers are reached over an Avalon-MM slave, word addressed.
// Notes: Offsets are byte offsets; the slave decodes address times four.
package seq_pkg;
   // Program counter, stack and pointer geometry.
   localparam int PC_WIDTH = 15;
   localparam int STACK_DEPTH = 16;
   localparam int STACK_AW = 4;
   localparam int PTR_WIDTH = 16;
   localparam int WORD_WIDTH = 14;
   localparam int DATA_WIDTH = 8;
   localparam int DM_AW = 12;
   localparam int CTX_WIDTH = 32;
   localparam int PM_WORDS_DEFAULT = 8192;

   // Fixed vectors and stack depth limits.
   localparam logic [14:0] RESET_VECTOR = 15'h0000;
   localparam logic [14:0] IRQ_VECTOR = 15'h0004;
   localparam logic [4:0] DEPTH_FULL = 5'h10;
   localparam logic [4:0] DEPTH_EMPTY = 5'h00;

   // Size of the instruction set reported to software.
   localparam logic [7:0] INSTR_COUNT = 8'h31;

   // Register byte offsets.
   localparam logic [4:0] OFF_POWER_CONTROL_STATUS = 5'h00;
   localparam logic [4:0] OFF_MASK = 5'h04;
   localparam logic [4:0] OFF_PC = 5'h08;
   localparam logic [4:0] OFF_DEPTH = 5'h0C;
   localparam logic [4:0] OFF_PTR0 = 5'h10;
   localparam logic [4:0] OFF_PTR1 = 5'h14;
   localparam logic [4:0] OFF_INFO = 5'h18;

   // Field positions of power_control_status and the mask.
   localparam int POWER_CONTROL_STATUS_UNF_BIT = 0;
   localparam int POWER_CONTROL_STATUS_OVF_BIT = 1;

   // Pointer space layout.
   localparam int PTR_PM_BIT = 15;
   localparam logic [15:0] LINEAR_BASE = 16'h2000;
   localparam logic [15:0] LINEAR_LAST = 16'h29FF;
   localparam logic [15:0] GPR_BANK_BYTES = 16'h0050;
   localparam logic [6:0] GPR_OFFSET = 7'h20;

   // Indirect access sequence.
   typedef enum logic [2:0]
   {
      ACC_IDLE = 3'b001,
      ACC_EXTRA = 3'b010,
      ACC_DATA = 3'b100
   } access_state_type;
endpackage : seq_pkg

// file: logic/stack_mem.sv
// Purpose: Return-address storage with a registered read port.
// Assumes: One write and one read per clock.
// Notes: A write to the address being read is forwarded to the read data.
`timescale 1ns/1ps
module stack_mem #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 16,
   parameter int AW = 4
)(
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   typedef struct packed
   {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0] rd;
   } mem_state_type;

   mem_state_type r;
   mem_state_type next_r;

   // Write the entry and fetch the entry at the read address.
   always_comb
   begin
      next_r = r;
      if (wr_en)
      begin
         next_r.mem[wr_addr] = wr_data;
      end
      if (wr_en && wr_addr == rd_addr)
      begin
         next_r.rd = wr_data;
      end
      else
      begin
         next_r.rd = r.mem[rd_addr];
      end
   end

   // Register the whole state.
   always_ff @(posedge clk)
   begin
      r <= next_r;
   end

   assign rd_data = r.rd;
endmodule : stack_mem

// file: verification/cpu_program_sequencer_tb_top.sv
// Purpose: Self-checking bench of the program sequencer.
// Assumes: The memory model answers on the far side of the block.
// Notes: Flow cases come from a table; stack, irq and pointers follow.
`timescale 1ns/1ps
module cpu_program_sequencer_tb_top;
   localparam int PMW = 8192;
   typedef struct packed
   {
      logic [4:0] op;
      logic [14:0] tgt;
      logic [14:0] pc;
      logic [4:0] dep;
   } row_type;
   // Steps as {irq_take, retfie, ret, call, jump}, target, pc, depth.
   row_type rows [9] = '{
      '{5'h01, 15'h7FF0, 15'h7FF0, 5'h00},
      '{5'h00, 15'h0000, 15'h7FF1, 5'h00},
      '{5'h02, 15'h0100, 15'h0100, 5'h01},
      '{5'h10, 15'h1234, 15'h0004, 5'h02},
      '{5'h08, 15'h0000, 15'h0101, 5'h01},
      '{5'h06, 15'h0300, 15'h7FF2, 5'h00},
      '{5'h04, 15'h0000, 15'h7FF3, 5'h00},
      '{5'h12, 15'h0500, 15'h0004, 5'h01},
      '{5'h04, 15'h0000, 15'h7FF4, 5'h00}};
   // Pointer, data address and byte of each data access.
   logic [35:0] lin [3] = '{36'h204F06F3C, 36'h20500A0C3, 36'h01231235A};
   logic clk, rst, stack_reset_strap, avs_read, avs_write, avs_waitrequest;
   logic irq, step, call, ret, retfie, irq_take, jump, ctx_restore;
   logic soft_reset, ptr_wr, ptr_sel, ind_req, ind_write, ind_sel;
   logic ind_done, ind_busy, dm_rd, dm_wr, s;
   logic [2:0] avs_address;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, ctx_in, ctx_out, q;
   logic [14:0] target, pc, pm_addr;
   logic [13:0] pm_rdata;
   logic [15:0] ptr_wdata;
   logic [7:0] ind_wdata, ind_rdata, dm_wdata, dm_rdata;
   logic [11:0] dm_addr, a;
   int num_errors, num_checks, n, cyc, sr_cnt, cr_cnt;

   cpu_program_sequencer #(.PM_WORDS(PMW)) DUT (
      .clk, .rst, .stack_reset_strap, .avs_address, .avs_read, .avs_write,
      .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest,
      .irq, .step, .call, .ret, .retfie, .irq_take, .jump, .target, .ctx_in,
      .ctx_out, .ctx_restore, .soft_reset, .pc, .pm_addr, .pm_rdata,
      .ptr_wr, .ptr_sel, .ptr_wdata, .ind_req, .ind_write, .ind_sel,
      .ind_wdata, .ind_rdata, .ind_done, .ind_busy, .dm_addr, .dm_rd,
      .dm_wr, .dm_wdata, .dm_rdata);
   mem_model mem (.clk, .pm_addr, .pm_rdata, .dm_addr, .dm_rd, .dm_wr,
      .dm_wdata, .dm_rdata);

   // Clock at 125 MHz.
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Counts output pulses and cuts a hang short.
   always @(posedge clk)
   begin
      cyc++;
      sr_cnt += (soft_reset === 1'b1);
      cr_cnt += (ctx_restore === 1'b1);
      if (cyc > 3000)
      begin
         num_errors++;
         end_sim();
      end
   end

   task automatic end_sim();
      begin
         if (num_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask : end_sim

   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      begin
         num_checks++;
         if (g !== e)
         begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
         end
      end
   endtask : chk

   task automatic rst_dut(input logic sv);
      begin
         @(posedge clk);
         rst <= 1'b1;
         stack_reset_strap <= sv;
         repeat (10) @(posedge clk);
         rst <= 1'b0;
         #1;
      end
   endtask : rst_dut

   task automatic bus(input logic w, input logic [4:0] o,
      input logic [31:0] d);
      begin
         @(posedge clk);
         avs_address <= o[4:2];
         avs_writedata <= d;
         avs_read <= ~w;
         avs_write <= w;
         @(posedge clk);
         while (avs_waitrequest !== 1'b0)
            @(posedge clk);
         q = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
      end
   endtask : bus

   task automatic stp(input logic [4:0] op, input logic [14:0] t);
      begin
         @(posedge clk);
         {irq_take, retfie, ret, call, jump} <= op;
         target <= t;
         ctx_in <= {17'h0, t};
         step <= 1'b1;
         @(posedge clk);
         step <= 1'b0;
         #1;
      end
   endtask : stp

   task automatic ind(input logic w, input logic l, input logic [7:0] d);
      begin
         n = 1;
         s = 1'b0;
         @(posedge clk);
         ind_req <= 1'b1;
         ind_write <= w;
         ind_sel <= l;
         ind_wdata <= d;
         @(posedge clk);
         ind_req <= 1'b0;
         #1;
         forever
         begin
            if (dm_rd === 1'b1 || dm_wr === 1'b1)
            begin
               s = 1'b1;
               a = dm_addr;
            end
            if (ind_done === 1'b1 || n > 8)
               break;
            @(posedge clk);
            #1;
            n++;
         end
      end
   endtask : ind

   task automatic irq_chk(input logic e);
      begin
         repeat (2) @(posedge clk);
         #1;
         chk("irq", {31'h0, e}, irq);
      end
   endtask : irq_chk

   // Main sequence: reset values, flow table, stack, irq, pointers.
   initial
   begin
      {rst, stack_reset_strap, avs_read, avs_write, step} = 5'b10000;
      {call, ret, retfie, irq_take, jump, ptr_wr, ptr_sel} = 7'h01;
      {ind_req, ind_write, ind_sel, avs_byteenable} = 7'h0F;
      {avs_address, avs_writedata, target, ctx_in} = '0;
      {ptr_wdata, ind_wdata} = '0;
      rst_dut(1'b0);
      chk("pc", 32'h0, pc);
      for (int i = 0; i < 8; i++)
      begin
         bus(1'b0, 5'(i * 4), 32'h0);
         chk("reg", (i == 6) ? 32'h31 : 32'h0, q);
      end
      for (int i = 0; i < 9; i++)
      begin
         stp(rows[i].op, rows[i].tgt);
         chk("pc", rows[i].pc, pc);
         chk("pm_addr", 32'(rows[i].pc) % PMW, pm_addr);
         if (rows[i].op == 5'h08)
            chk("ctx_out", 32'h1234, ctx_out);
         bus(1'b0, seq_pkg::OFF_DEPTH, 32'h0);
         chk("depth", rows[i].dep, q);
      end
      chk("restores", 32'h1, cr_cnt);
      chk("soft_reset", 32'h0, sr_cnt);
      bus(1'b0, seq_pkg::OFF_POWER_CONTROL_STATUS, 32'h0);
      chk("status", 32'h1, q);
      bus(1'b1, seq_pkg::OFF_MASK, 32'h1);
      irq_chk(1'b1);
      bus(1'b1, seq_pkg::OFF_POWER_CONTROL_STATUS, 32'h1);
      irq_chk(1'b0);
      // Seventeen calls overrun the sixteen entries.
      for (int k = 1; k <= 17; k++)
         stp(5'h02, 15'(k * 16));
      bus(1'b0, seq_pkg::OFF_POWER_CONTROL_STATUS, 32'h0);
      chk("status", 32'h2, q);
      irq_chk(1'b0);
      bus(1'b1, seq_pkg::OFF_MASK, 32'h3);
      irq_chk(1'b1);
      bus(1'b1, seq_pkg::OFF_POWER_CONTROL_STATUS, 32'h2);
      irq_chk(1'b0);
      for (int j = 16; j >= 1; j--)
      begin
         stp(5'h04, 15'h0);
         chk("pc", (j == 1) ? 32'h7FF5 : 32'(16 * j - 15), pc);
      end
      bus(1'b1, seq_pkg::OFF_PTR0, 32'h8123);
      bus(1'b0, seq_pkg::OFF_PTR0, 32'h0);
      chk("ptr0", 32'h8123, q);
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk);
         ptr_wr <= 1'b1;
         ptr_wdata <= lin[i][35:20];
         @(posedge clk);
         ptr_wr <= 1'b0;
         ind(1'b1, 1'b1, lin[i][7:0]);
         chk("dm_addr", lin[i][19:8], a);
         ind(1'b0, 1'b1, 8'h00);
         chk("cycles", 32'h2, n);
         chk("ind_rdata", lin[i][7:0], ind_rdata);
      end
      ind(1'b0, 1'b0, 8'h00);
      chk("cycles", 32'h3, n);
      chk("ind_rdata", 32'h79, ind_rdata);
      chk("strobe", 32'h0, s);
      ind(1'b1, 1'b0, 8'hEE);
      chk("strobe", 32'h0, s);
      ind(1'b0, 1'b0, 8'h00);
      chk("ind_rdata", 32'h79, ind_rdata);
      // A stack underflow with the reset option set.
      rst_dut(1'b1);
      chk("pc", 32'h0, pc);
      bus(1'b0, seq_pkg::OFF_INFO, 32'h0);
      chk("info", 32'h131, q);
      bus(1'b1, seq_pkg::OFF_PTR0, 32'h77);
      stp(5'h04, 15'h0);
      repeat (3) @(posedge clk);
      #1;
      chk("soft_reset", 32'h1, sr_cnt);
      chk("pc", 32'h0, pc);
      bus(1'b0, seq_pkg::OFF_PTR0, 32'h0);
      chk("ptr0", 32'h0, q);
      bus(1'b0, seq_pkg::OFF_POWER_CONTROL_STATUS, 32'h0);
      chk("status", 32'h1, q);
      end_sim();
   end
endmodule : cpu_program_sequencer_tb_top

// file: verification/mem_model.sv
// Purpose: Program and data memory on the far side of the sequencer.
// Assumes: Program words are a fixed pattern of their address.
// Notes: An idle data bus shows the inverse of its last value.
`timescale 1ns/1ps
module mem_model (
   input wire logic clk,
   input wire logic [14:0] pm_addr,
   output logic [13:0] pm_rdata,
   input wire logic [11:0] dm_addr,
   input wire logic dm_rd,
   input wire logic dm_wr,
   input wire logic [7:0] dm_wdata,
   output logic [7:0] dm_rdata
);
   logic [7:0] mem [0:4095];
   logic rd_q;
   logic [11:0] a_q;
   logic [7:0] last;
   // Program words follow their address by one cycle; data writes land.
   always_ff @(posedge clk)
   begin
      pm_rdata <= pm_addr[13:0] ^ 14'h3C5A;
      rd_q <= dm_rd;
      if (dm_rd)
         a_q <= dm_addr;
      last <= dm_rdata;
      if (dm_wr)
         mem[dm_addr] <= dm_wdata;
   end
   // Read data stands in the strobe cycle and the next, then goes stale.
   assign dm_rdata = dm_rd ? mem[dm_addr] : rd_q ? mem[a_q] : ~last;
endmodule : mem_model
